// file: design/i2clx_core.sv
`timescale 1ns/100ps
module i2clx_core
  import i2clx_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        enable_in,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             ready_n_out,
  output logic             ready_n_oe,
  output logic             link_up_n_out,
  output logic             link_up_n_oe,
  output logic             xcvr_sleep,
  input  wire logic        link_clk,
  input  wire logic        link_rx,
  output logic             link_tx,
  output logic             link_tx_oe,
  input  wire logic        rate_select_1,
  input  wire logic        rate_select_2,
  input  wire logic        slew_limit_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  function automatic logic [CNT_W-1:0] setup_cycles(input logic [1:0] idx);
    unique case (idx)
      2'h0: setup_cycles = SETUP0_CYCLES;
      2'h1: setup_cycles = SETUP1_CYCLES;
      2'h2: setup_cycles = SETUP2_CYCLES;
      2'h3: setup_cycles = SETUP3_CYCLES;
    endcase
  endfunction : setup_cycles

  logic [7:0]             sync1_reg;
  logic [7:0]             sync2_reg;
  logic                   scl_q_reg;
  logic                   sda_q_reg;
  logic                   lclk_q_reg;
  logic                   active_reg;
  logic [CNT_W-1:0]       init_cnt_reg;
  logic [CNT_W-1:0]       idle_cnt_reg;
  logic                   ready_reg;
  logic                   link_up_reg;
  logic [31:0]            cfg_reg;
  logic                   fault_reg;
  logic                   supp_reg;
  i2clx_state_type        state_reg;
  logic [3:0]             bit_cnt_reg;
  logic [7:0]             shift_reg;
  logic [7:0]             rbyte_reg;
  logic                   rvalid_reg;
  logic                   ack_got_reg;
  logic                   ack_nack_reg;
  logic                   nack_reg;
  logic                   is_addr_reg;
  logic                   is_read_reg;
  logic                   need_push_reg;
  logic [CNT_W-1:0]       setup_cnt_reg;
  logic                   push_reg;
  logic [MSG_W-1:0]       push_msg_reg;
  logic [MSG_W-1:0]       fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW:0]       wr_ptr_reg;
  logic [FIFO_AW:0]       rd_ptr_reg;
  logic                   rx_busy_reg;
  logic [3:0]             rx_cnt_reg;
  logic [MSG_W-1:0]       rx_sh_reg;
  logic                   rx_done_reg;
  logic [MSG_W-1:0]       rx_msg_reg;
  logic                   tx_busy_reg;
  logic [3:0]             tx_cnt_reg;
  logic [FRAME_BITS-1:0]  tx_sh_reg;

  logic       run;
  logic       scl_s;
  logic       sda_s;
  logic       lclk_s;
  logic       lrx_s;
  logic [1:0] speed_idx;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       lclk_rise;
  logic       lclk_fall;
  logic       fifo_full;
  logic       fifo_empty;
  logic       fwd_ok;
  logic       access;
  logic       apb_wr;
  logic [2:0] rx_type;
  logic [7:0] rx_data;

  assign run       = sync2_reg[0];
  assign scl_s     = sync2_reg[1];
  assign sda_s     = sync2_reg[2];
  assign lclk_s    = sync2_reg[3];
  assign lrx_s     = sync2_reg[4];
  assign speed_idx = sync2_reg[6:5];
  assign scl_rise  = scl_s & ~scl_q_reg;
  assign scl_fall  = ~scl_s & scl_q_reg;
  assign bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign lclk_rise = lclk_s & ~lclk_q_reg;
  assign lclk_fall = ~lclk_s & lclk_q_reg;
  assign fifo_full  = (wr_ptr_reg - rd_ptr_reg) == (FIFO_AW+1)'(FIFO_DEPTH);
  assign fifo_empty = wr_ptr_reg == rd_ptr_reg;
  assign fwd_ok  = active_reg & link_up_reg & cfg_reg[CFG_FWD_BIT];
  assign access  = psel & penable;
  assign apb_wr  = access & pready & pwrite;
  assign rx_type = rx_msg_reg[10:8];
  assign rx_data = rx_msg_reg[7:0];

  // input synchronisers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      lclk_q_reg <= 1'b0;
    end else begin
      sync1_reg <= {slew_limit_n, rate_select_2, rate_select_1, link_rx,
                    link_clk, sda_in, scl_in, enable_in};
      sync2_reg <= sync1_reg;
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
      lclk_q_reg <= lclk_s;
    end
  end

  // startup sequence and enable handling
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
      init_cnt_reg <= '0;
      xcvr_sleep <= 1'b1;
    end else if (!run) begin
      active_reg <= 1'b0;
      init_cnt_reg <= '0;
      xcvr_sleep <= 1'b1;
    end else begin
      xcvr_sleep <= 1'b0;
      if (init_cnt_reg == INIT_CYCLES) begin
        active_reg <= 1'b1;
      end else begin
        init_cnt_reg <= init_cnt_reg + 1'b1;
      end
    end
  end

  // idle detector and status pins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_reg <= '0;
      ready_reg <= 1'b0;
      ready_n_oe <= 1'b0;
      link_up_n_oe <= 1'b0;
      ready_n_out <= 1'b0;
      link_up_n_out <= 1'b0;
    end else if (!active_reg) begin
      idle_cnt_reg <= '0;
      ready_reg <= 1'b0;
      ready_n_oe <= 1'b0;
      link_up_n_oe <= 1'b0;
    end else begin
      if (!scl_s) begin
        idle_cnt_reg <= '0;
      end else if (idle_cnt_reg != IDLE_CYCLES) begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
      if (bus_stop || idle_cnt_reg == IDLE_CYCLES) begin
        ready_reg <= 1'b1;
      end
      ready_n_oe <= ready_reg | fifo_full;
      link_up_n_oe <= link_up_reg & ready_reg;
    end
  end

  // apb slave
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      cfg_reg <= CFG_RESET;
    end else begin
      pready <= access & ~pready;
      if (access && !pready) begin
        pslverr <= 1'b0;
        prdata <= '0;
        unique case (paddr)
          ADDR_CFG: prdata <= cfg_reg;
          ADDR_STATUS: begin
            prdata[ST_ACTIVE_BIT] <= active_reg;
            prdata[ST_READY_BIT] <= ready_reg;
            prdata[ST_LINK_BIT] <= link_up_reg;
            prdata[ST_FULL_BIT] <= fifo_full;
            prdata[ST_SUPP_BIT] <= supp_reg;
            prdata[ST_FAULT_BIT] <= fault_reg;
            prdata[ST_SLEW_BIT] <= sync2_reg[7];
          end
          ADDR_RATE: prdata <= {30'h0000_0000, speed_idx};
          default: pslverr <= 1'b1;
        endcase
      end
      if (!run) begin
        cfg_reg <= CFG_RESET;
      end else if (apb_wr && paddr == ADDR_CFG) begin
        cfg_reg <= {pwdata[31:2], 1'b0, pwdata[0]};
      end
    end
  end

  // outgoing message queue
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
    end else if (!active_reg) begin
      wr_ptr_reg <= '0;
    end else if (push_reg && !fifo_full) begin
      fifo_mem[wr_ptr_reg[FIFO_AW-1:0]] <= push_msg_reg;
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // link receiver, sampled on link clock rising edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_sh_reg <= '0;
      rx_done_reg <= 1'b0;
      rx_msg_reg <= '0;
      link_up_reg <= 1'b0;
    end else if (!active_reg) begin
      rx_busy_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      link_up_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (lclk_rise) begin
        if (!rx_busy_reg) begin
          rx_busy_reg <= lrx_s;
          rx_cnt_reg <= '0;
        end else begin
          rx_sh_reg <= {rx_sh_reg[MSG_W-2:0], lrx_s};
          rx_cnt_reg <= rx_cnt_reg + 1'b1;
          if (rx_cnt_reg == 4'(MSG_W - 1)) begin
            rx_busy_reg <= 1'b0;
            rx_done_reg <= 1'b1;
            rx_msg_reg <= {rx_sh_reg[MSG_W-2:0], lrx_s};
          end
        end
      end
      if (rx_done_reg && rx_type == MSG_PROBE) begin
        link_up_reg <= 1'b1;
      end
    end
  end

  // link transmitter, shifts on link clock falling edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_reg <= '0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= '0;
      tx_sh_reg <= '0;
      link_tx <= 1'b0;
      link_tx_oe <= 1'b0;
    end else if (!active_reg) begin
      rd_ptr_reg <= '0;
      tx_busy_reg <= 1'b0;
      link_tx <= 1'b0;
      link_tx_oe <= 1'b0;
    end else begin
      link_tx_oe <= 1'b1;
      if (lclk_fall) begin
        if (tx_busy_reg) begin
          link_tx <= tx_sh_reg[FRAME_BITS-1];
          tx_sh_reg <= {tx_sh_reg[FRAME_BITS-2:0], 1'b0};
          tx_cnt_reg <= tx_cnt_reg - 1'b1;
          if (tx_cnt_reg == 4'h1) begin
            tx_busy_reg <= 1'b0;
          end
        end else if (!fifo_empty) begin
          tx_sh_reg <= {1'b1, fifo_mem[rd_ptr_reg[FIFO_AW-1:0]]};
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
          tx_busy_reg <= 1'b1;
          tx_cnt_reg <= 4'(FRAME_BITS);
          link_tx <= 1'b0;
        end else if (!link_up_reg) begin
          tx_sh_reg <= {1'b1, MSG_PROBE, 8'h00};
          tx_busy_reg <= 1'b1;
          tx_cnt_reg <= 4'(FRAME_BITS);
          link_tx <= 1'b0;
        end else begin
          link_tx <= 1'b0;
        end
      end
    end
  end

  // bus slave state machine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= I2CLX_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      rbyte_reg <= '0;
      rvalid_reg <= 1'b0;
      ack_got_reg <= 1'b0;
      ack_nack_reg <= 1'b0;
      nack_reg <= 1'b0;
      is_addr_reg <= 1'b0;
      is_read_reg <= 1'b0;
      need_push_reg <= 1'b0;
      setup_cnt_reg <= '0;
      push_reg <= 1'b0;
      push_msg_reg <= '0;
      supp_reg <= 1'b0;
      fault_reg <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (!fwd_ok) begin
      state_reg <= I2CLX_IDLE;
      rvalid_reg <= 1'b0;
      ack_got_reg <= 1'b0;
      need_push_reg <= 1'b0;
      push_reg <= 1'b0;
      supp_reg <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      if (!active_reg) begin
        fault_reg <= 1'b0;
      end
    end else begin
      push_reg <= 1'b0;
      // set wins over clear for answers from the link, but a bus start or stop in the same cycle clears ack_got_reg and rvalid_reg
      if (rx_done_reg && rx_type == MSG_ACK) begin
        ack_got_reg <= 1'b1;
        ack_nack_reg <= rx_data[0];
      end else if (state_reg == I2CLX_ACK_WAIT && ack_got_reg) begin
        ack_got_reg <= 1'b0;
      end
      if (rx_done_reg && rx_type == MSG_RDATA) begin
        rbyte_reg <= rx_data;
        rvalid_reg <= 1'b1;
      end else if (state_reg == I2CLX_TX_WAIT && rvalid_reg) begin
        rvalid_reg <= 1'b0;
      end
      if (rx_done_reg && rx_type == MSG_FAULT) begin
        fault_reg <= 1'b1;
      end else if (apb_wr && paddr == ADDR_CFG && pwdata[CFG_FCLR_BIT]) begin
        fault_reg <= 1'b0;
      end
      if (bus_start || bus_stop) begin
        // stop or start ends any byte sequence
        push_reg <= 1'b1;
        push_msg_reg <= {bus_start ? MSG_START : MSG_STOP, 8'h00};
        state_reg <= bus_start ? I2CLX_RX : I2CLX_IDLE;
        bit_cnt_reg <= '0;
        is_addr_reg <= 1'b1;
        supp_reg <= 1'b0;
        ack_got_reg <= 1'b0;
        rvalid_reg <= 1'b0;
        need_push_reg <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        unique case (state_reg)
          I2CLX_IDLE: begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
          I2CLX_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              scl_oe <= 1'b1;
              need_push_reg <= 1'b1;
              is_read_reg <= is_addr_reg ? shift_reg[0] : is_read_reg;
              state_reg <= I2CLX_ACK_WAIT;
            end
          end
          I2CLX_ACK_WAIT: begin
            scl_oe <= 1'b1;
            if (need_push_reg && !fifo_full) begin
              push_reg <= 1'b1;
              push_msg_reg <= {MSG_DATA, shift_reg};
              need_push_reg <= 1'b0;
            end
            if (ack_got_reg && !need_push_reg) begin
              nack_reg <= ack_nack_reg;
              sda_oe <= ~ack_nack_reg;
              setup_cnt_reg <= setup_cycles(speed_idx);
              state_reg <= I2CLX_ACK_DRIVE;
            end
          end
          I2CLX_ACK_DRIVE: begin
            if (setup_cnt_reg != '0) begin
              setup_cnt_reg <= setup_cnt_reg - 1'b1;
            end else begin
              scl_oe <= 1'b0;
            end
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt_reg <= '0;
              is_addr_reg <= 1'b0;
              if (nack_reg && is_addr_reg) begin
                supp_reg <= 1'b1;
                state_reg <= I2CLX_HOLD_OFF;
              end else if (is_read_reg && !nack_reg) begin
                scl_oe <= 1'b1;
                state_reg <= I2CLX_TX_WAIT;
              end else begin
                state_reg <= I2CLX_RX;
              end
            end
          end
          I2CLX_TX_WAIT: begin
            scl_oe <= 1'b1;
            if (rvalid_reg) begin
              shift_reg <= rbyte_reg;
              sda_oe <= ~rbyte_reg[7];
              setup_cnt_reg <= setup_cycles(speed_idx);
              state_reg <= I2CLX_TX_BIT;
            end
          end
          I2CLX_TX_BIT: begin
            if (setup_cnt_reg != '0) begin
              setup_cnt_reg <= setup_cnt_reg - 1'b1;
            end else begin
              scl_oe <= 1'b0;
            end
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h7) begin
                sda_oe <= 1'b0;
                state_reg <= I2CLX_MACK;
              end else begin
                scl_oe <= 1'b1;
                sda_oe <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                setup_cnt_reg <= setup_cycles(speed_idx);
              end
            end
          end
          I2CLX_MACK: begin
            if (scl_rise) begin
              nack_reg <= sda_s;
              push_reg <= 1'b1;
              push_msg_reg <= {MSG_ACK, 7'h00, sda_s};
            end else if (scl_fall) begin
              bit_cnt_reg <= '0;
              if (!nack_reg) begin
                scl_oe <= 1'b1;
                state_reg <= I2CLX_TX_WAIT;
              end else begin
                state_reg <= I2CLX_HOLD_OFF;
              end
            end
          end
          I2CLX_HOLD_OFF: begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : i2clx_core

// file: dv/i2clx_core_assertions.sv
`timescale 1ns/100ps
module i2clx_core_assertions
  import i2clx_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic ready_n_oe,
  input wire logic link_up_n_oe,
  input wire logic link_tx_oe,
  input wire logic xcvr_sleep,
  input wire logic link_clk,
  input wire logic link_tx,
  input wire logic rate_select_1,
  input wire logic rate_select_2
);
  logic [15:0] cnt_reg;
  logic        act_reg;
  wire logic   quiet;
  assign quiet = !(scl_oe || sda_oe || ready_n_oe || link_up_n_oe
                   || link_tx_oe);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // cycles since reset or enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b || !enable_in) cnt_reg <= 16'h0000;
    else if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
  end
  // any bus activity seen
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b || !enable_in) act_reg <= 1'b0;
    else if (!scl_in || !sda_in) act_reg <= 1'b1;
  end
  a_init_quiet: assert property (
    enable_in && cnt_reg < INIT_CYCLES |-> quiet)
    else $error("output driven during init");
  a_low_power: assert property (
    !enable_in [*5] |-> xcvr_sleep && quiet)
    else $error("outputs active while disabled");
  a_setup_hold: assert property (
    $rose(sda_oe) && scl_oe && !rate_select_1 && !rate_select_2
    |-> scl_oe [*8])
    else $error("scl released before data setup");
  a_grab_low: assert property (
    $rose(scl_oe) |-> !scl_in)
    else $error("scl stretched during high phase");
  a_sda_change: assert property (
    enable_in && $changed(sda_oe) |-> !scl_in)
    else $error("sda moved while scl high");
  a_link_ready: assert property (
    link_up_n_oe |-> ready_n_oe)
    else $error("link status before bus ready");
  a_tx_edge: assert property (
    enable_in && $changed(link_tx) |-> !link_clk)
    else $error("link data moved at sampling edge");
  a_ready_idle: assert property (
    $rose(ready_n_oe) && !act_reg |-> cnt_reg >= IDLE_CYCLES)
    else $error("ready before idle time");
endmodule : i2clx_core_assertions

bind i2clx_core i2clx_core_assertions i_i2clx_core_assertions (
  .clock(clock), .rst_b(rst_b), .enable_in(enable_in),
  .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .ready_n_oe(ready_n_oe), .link_up_n_oe(link_up_n_oe),
  .link_tx_oe(link_tx_oe), .xcvr_sleep(xcvr_sleep),
  .link_clk(link_clk), .link_tx(link_tx),
  .rate_select_1(rate_select_1), .rate_select_2(rate_select_2)
);

// file: dv/i2clx_core_bench.sv
`timescale 1ns/100ps
module i2clx_core_bench
  import i2clx_pkg::*;
;
  logic        clock, rst_b, enable_in, link_clk, link_rx;
  logic        rate_select_1, rate_select_2, slew_limit_n;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        scl_out, scl_oe, sda_out, sda_oe, xcvr_sleep;
  logic        ready_n_out, ready_n_oe, link_up_n_out, link_up_n_oe;
  logic        link_tx, link_tx_oe, m_scl, m_sda;
  wire logic   scl_line, sda_line;
  wire logic [5:0] oes;
  int          errors, samples_checked;
  int          cyc = 0;
  assign scl_line = !(m_scl || (scl_oe && !scl_out));
  assign sda_line = !(m_sda || (sda_oe && !sda_out));
  assign oes = {scl_oe, sda_oe, ready_n_oe, link_up_n_oe, link_tx_oe,
                xcvr_sleep};
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  i2clx_core i_i2clx_core (
    .clock(clock), .rst_b(rst_b), .enable_in(enable_in),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .ready_n_out(ready_n_out), .ready_n_oe(ready_n_oe),
    .link_up_n_out(link_up_n_out), .link_up_n_oe(link_up_n_oe),
    .xcvr_sleep(xcvr_sleep), .link_clk(link_clk), .link_rx(link_rx),
    .link_tx(link_tx), .link_tx_oe(link_tx_oe),
    .rate_select_1(rate_select_1), .rate_select_2(rate_select_2),
    .slew_limit_n(slew_limit_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  i2clx_master_model i_i2clx_master_model (
    .clock(clock), .scl(scl_line), .sda(sda_line),
    .scl_drv(m_scl), .sda_drv(m_sda));
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // remote twin: send one frame (unless m is zero), catch one frame
  task automatic lk(input logic [10:0] m, output logic [10:0] g);
    int n, k;
    logic [11:0] s;
    logic snd;
    s = {1'h1, m};
    snd = (m !== 11'h000);
    k = -1;
    g = 11'h000;
    for (n = 0; n < 128 && (k != 11 || (snd && n < 12)); n++) begin
      link_clk <= 1'b0;
      link_rx  <= (snd && n < 12) ? s[11-n] : 1'b0;
      repeat (4) @(posedge clock);
      link_clk <= 1'b1;
      if (k >= 0 && k < 11) begin
        g = {g[9:0], link_tx};
        k++;
      end else if (k < 0 && link_tx === 1'b1) k = 0;
      repeat (4) @(posedge clock);
    end
  endtask : lk
  task automatic wr(input logic [7:0] b, input logic nk);
    logic a;
    logic [10:0] g;
    fork
      i_i2clx_master_model.xfer(b, a);
      begin
        lk(11'h000, g);
        chk(g, {MSG_DATA, b}, "data frame");
        lk({MSG_ACK, 7'h00, nk}, g);
      end
    join
    chk(a, !nk, "ack on bus");
  endtask : wr
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    logic [31:0] r;
    logic        e, a;
    logic [10:0] g;
    int          n;
    rst_b = 1'b0;
    enable_in = 1'b1;
    link_clk = 1'b0;
    link_rx = 1'b0;
    rate_select_1 = 1'b0;
    rate_select_2 = 1'b0;
    slew_limit_n = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clock);
    chk(oes, 6'h01, "reset outputs");
    rst_b <= 1'b1;
    repeat (100) @(posedge clock);
    chk(oes[5:1], 5'h00, "init outputs");
    apb(1'h0, ADDR_CFG, 32'h0000_0000, r, e);
    chk(r, CFG_RESET, "cfg reset");
    apb(1'h1, 12'h0FC, 32'h0000_00FF, r, e);
    chk(e, 1'h1, "unmapped");
    apb(1'h0, ADDR_RATE, 32'h0000_0000, r, e);
    chk(r[1:0], 2'h0, "rate");
    for (n = 0; n < 4000 && ready_n_oe !== 1'b1; n++) @(posedge clock);
    chk(ready_n_oe, 1'h1, "ready");
    chk(link_up_n_oe, 1'h0, "link before probe");
    lk({MSG_PROBE, 8'h00}, g);
    chk(g[10:8], MSG_PROBE, "probe while down");
    for (n = 0; n < 500 && link_up_n_oe !== 1'b1; n++) @(posedge clock);
    chk(link_up_n_oe, 1'h1, "link up");
    chk({ready_n_out, link_up_n_out}, 2'h0, "pin low levels");
    lk(11'h000, g);
    i_i2clx_master_model.start();
    lk(11'h000, g);
    chk(g[10:8], MSG_START, "start frame");
    wr(8'hA4, 1'b0);
    wr(8'h5C, 1'b0);
    i_i2clx_master_model.stop();
    lk(11'h000, g);
    chk(g[10:8], MSG_STOP, "stop frame");
    i_i2clx_master_model.start();
    lk(11'h000, g);
    wr(8'hA5, 1'b0);
    fork
      i_i2clx_master_model.xfer(8'hFF, a);
      lk({MSG_RDATA, 8'h5A}, g);
    join
    chk(i_i2clx_master_model.rx_byte, 8'h5A, "read byte");
    chk(g, {MSG_ACK, 8'h01}, "master nack");
    i_i2clx_master_model.stop();
    lk(11'h000, g);
    i_i2clx_master_model.start();
    lk(11'h000, g);
    wr(8'h90, 1'b1);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000, r, e);
    chk(r[ST_SUPP_BIT], 1'h1, "suppressed");
    i_i2clx_master_model.xfer(8'h33, a);
    chk(a, 1'h0, "no answer");
    i_i2clx_master_model.stop();
    lk(11'h000, g);
    chk(g[10:8], MSG_STOP, "only stop");
    apb(1'h1, ADDR_CFG, 32'h0000_0000, r, e);
    enable_in <= 1'b0;
    repeat (6) @(posedge clock);
    chk(oes, 6'h01, "enable low");
    enable_in <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'h0, ADDR_CFG, 32'h0000_0000, r, e);
    chk(r, CFG_RESET, "cfg default");
    summarize();
  end
endmodule : i2clx_core_bench

// file: dv/i2clx_master_model.sv
`timescale 1ns/100ps
module i2clx_master_model (
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv
);
  logic [7:0] rx_byte;
  initial begin
    scl_drv = 1'b0;
    sda_drv = 1'b0;
  end
  task automatic hc();
    repeat (10) @(posedge clock);
  endtask : hc
  // release scl, wait out any stretch, then high phase
  task automatic rise();
    int n;
    scl_drv <= 1'b0;
    n = 0;
    @(posedge clock);
    while (scl !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    hc();
  endtask : rise
  task automatic start();
    @(posedge clock);
    sda_drv <= 1'b1;
    hc();
    scl_drv <= 1'b1;
    hc();
  endtask : start
  task automatic stop();
    @(posedge clock);
    sda_drv <= 1'b1;
    hc();
    rise();
    sda_drv <= 1'b0;
    hc();
  endtask : stop
  task automatic xfer(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) begin
      sda_drv <= !b[i];
      hc();
      rise();
      rx_byte = {rx_byte[6:0], sda};
      scl_drv <= 1'b1;
      hc();
    end
    sda_drv <= 1'b0;
    hc();
    rise();
    ack = (sda === 1'b0);
    scl_drv <= 1'b1;
    hc();
  endtask : xfer
endmodule : i2clx_master_model

// file: include/i2clx_pkg.sv
package i2clx_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int INIT_TIME_NS  = 10000;
  localparam int IDLE_WAIT_NS  = 50000;
  localparam int SETUP0_NS     = 250;
  localparam int SETUP1_NS     = 100;
  localparam int SETUP2_NS     = 50;
  localparam int SETUP3_NS     = 50;

  // least time, rounded up, never below one cycle
  function automatic int i2clx_ns_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : i2clx_ns_cycles

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] INIT_CYCLES =
    CNT_W'(i2clx_ns_cycles(INIT_TIME_NS));
  localparam logic [CNT_W-1:0] IDLE_CYCLES =
    CNT_W'(i2clx_ns_cycles(IDLE_WAIT_NS));
  localparam logic [CNT_W-1:0] SETUP0_CYCLES =
    CNT_W'(i2clx_ns_cycles(SETUP0_NS));
  localparam logic [CNT_W-1:0] SETUP1_CYCLES =
    CNT_W'(i2clx_ns_cycles(SETUP1_NS));
  localparam logic [CNT_W-1:0] SETUP2_CYCLES =
    CNT_W'(i2clx_ns_cycles(SETUP2_NS));
  localparam logic [CNT_W-1:0] SETUP3_CYCLES =
    CNT_W'(i2clx_ns_cycles(SETUP3_NS));

  // link frame: marker bit, 3-bit type, 8-bit payload, msb first
  localparam int FRAME_BITS = 12;
  localparam int MSG_W      = 11;
  localparam logic [2:0] MSG_START = 3'h1;
  localparam logic [2:0] MSG_STOP  = 3'h2;
  localparam logic [2:0] MSG_DATA  = 3'h3;
  localparam logic [2:0] MSG_ACK   = 3'h4;
  localparam logic [2:0] MSG_RDATA = 3'h5;
  localparam logic [2:0] MSG_FAULT = 3'h6;
  localparam logic [2:0] MSG_PROBE = 3'h7;

  // outgoing queue
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW    = 2;

  // register map
  localparam logic [11:0] ADDR_CFG    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RATE   = 12'h008;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0001;
  localparam int CFG_FWD_BIT   = 0;
  localparam int CFG_FCLR_BIT  = 1;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_READY_BIT  = 1;
  localparam int ST_LINK_BIT   = 2;
  localparam int ST_FULL_BIT   = 3;
  localparam int ST_SUPP_BIT   = 4;
  localparam int ST_FAULT_BIT  = 5;
  localparam int ST_SLEW_BIT   = 6;

  // synchroniser vector reset (scl and sda idle high)
  localparam logic [7:0] SYNC_RESET = 8'h06;

  typedef enum logic [2:0] {
    I2CLX_IDLE,
    I2CLX_RX,
    I2CLX_ACK_WAIT,
    I2CLX_ACK_DRIVE,
    I2CLX_TX_WAIT,
    I2CLX_TX_BIT,
    I2CLX_MACK,
    I2CLX_HOLD_OFF
  } i2clx_state_type;

endpackage : i2clx_pkg
